// >>> rtl/pin_mux.sv
// parallel port address/data pin multiplexer with flag mode
// Notes on behaviour
// - setup bit 20 plus port disabled: flags
// - flag mode swaps bus bytes to flags
// - 8-bit latch phase: A15-8 low, A23-16 high
// - 8-bit data phase: D7-0 low, A7-0 high
// - 16-bit latch phase: A7-0 low, A15-8 high
// - 16-bit data phase: D15-0 on all pins
// - read, write, latch strobes always driven
`include "pin_mux_cfg.svh"
module pin_mux
  import pin_mux_pkg::*;
(
  input wire logic CLK_SYS_IN, // core clock 125 MHz
  input wire logic RST_N_IN, // async reset, active low
  input wire logic [31:0] SETUP_REG_IN, // system setup register value
  input wire logic PORT_EN_IN, // parallel port enabled
  input wire logic WIDE_MODE_IN, // 1 = 16-bit data, 0 = 8-bit
  input wire logic LATCH_IN, // address latch phase from port
  input wire logic RD_IN, // read strobe from port, active high
  input wire logic WR_IN, // write strobe from port, active high
  input wire logic [23:0] ADDR_IN, // port address
  input wire logic [15:0] WDATA_IN, // port write data
  input wire logic [15:0] FLAG_OUT_IN, // software flag output values
  input wire logic [15:0] FLAG_OE_IN, // software flag output enables
  input wire logic [15:0] BUS_PIN_IN, // muxed bus pins, pad input
  output logic [15:0] BUS_PIN_OUT, // muxed bus pins, pad output
  output logic [15:0] BUS_PIN_OE_OUT, // muxed bus pins, output enable
  output logic [15:0] RDATA_OUT, // port read data
  output logic [15:0] FLAG_IN_OUT, // software flag input values
  output logic LATCH_OUT, // latch strobe pin, active high
  output logic RD_N_OUT, // read strobe pin, active low
  output logic WR_N_OUT // write strobe pin, active low
);

  ////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [15:0] swap_bytes(input logic [15:0] v);
    return {v[`LO_BYTE_MSB:0], v[15:`HI_BYTE_LSB]};
  endfunction
  // port modes own the strobes; shared by all three strobe terms
  // so that a new port mode needs one edit only
  function automatic logic is_port_mode(input pin_mode_t m);
    return (m == MODE_PP8) || (m == MODE_PP16);
  endfunction

  pin_mode_t mode_r;
  logic [15:0] pin_sync;
  logic [15:0] out_nxt;
  logic [15:0] oe_nxt;

  ////////////////////////////////////////////////////////////////////////
  // pad inputs come from outside: synchronise before use
  sync2 #(.W(16)) u_sync (
    .clk_in(CLK_SYS_IN),
    .rst_n_in(RST_N_IN),
    .d_in(BUS_PIN_IN),
    .q_out(pin_sync)
  );

  // mode decode; flag mode only when the port is off
  // a mode change costs one cycle before the pins follow
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      mode_r <= MODE_IDLE;
    end else if (SETUP_REG_IN[`FLAG_MODE_BIT] && !PORT_EN_IN) begin
      mode_r <= MODE_FLAG;
    end else if (PORT_EN_IN) begin
      mode_r <= WIDE_MODE_IN ? MODE_PP16 : MODE_PP8;
    end else begin
      mode_r <= MODE_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next pin value by mode and latch phase
  always_comb begin
    out_nxt = 16'h0000;
    oe_nxt = 16'h0000;
    case (mode_r)
      MODE_FLAG: begin
        out_nxt = swap_bytes(FLAG_OUT_IN);
        oe_nxt = swap_bytes(FLAG_OE_IN);
      end
      MODE_PP8: begin
        oe_nxt = 16'hFFFF;
        if (LATCH_IN) begin
          out_nxt = ADDR_IN[23:8];
        end else begin
          out_nxt = {ADDR_IN[7:0], WDATA_IN[7:0]};
          // low byte turns round for reads; high byte keeps address
          oe_nxt = WR_IN ? 16'hFFFF : 16'hFF00;
        end
      end
      MODE_PP16: begin
        oe_nxt = 16'hFFFF;
        if (LATCH_IN) begin
          out_nxt = ADDR_IN[15:0];
        end else begin
          out_nxt = WDATA_IN;
          oe_nxt = WR_IN ? 16'hFFFF : 16'h0000;
        end
      end
      default: begin
        out_nxt = 16'h0000;
        oe_nxt = 16'h0000;
      end
    endcase
  end

  // pins registered; the external latch holds the address
  // one cycle from request to pin keeps the pad timing clean
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      BUS_PIN_OUT <= `BUS_RST;
      BUS_PIN_OE_OUT <= `BUS_RST;
    end else begin
      BUS_PIN_OUT <= out_nxt;
      BUS_PIN_OE_OUT <= oe_nxt;
    end
  end

  // strobes: plain outputs with no enable, never floated
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      LATCH_OUT <= `LATCH_RST;
      RD_N_OUT <= `STRB_N_RST;
      WR_N_OUT <= `STRB_N_RST;
    end else begin
      LATCH_OUT <= is_port_mode(mode_r) && LATCH_IN;
      RD_N_OUT <= !(is_port_mode(mode_r) && RD_IN);
      WR_N_OUT <= !(is_port_mode(mode_r) && WR_IN);
    end
  end

  // inputs from pads, routed by mode
  // three cycles from pad to read data: two sync stages, one register
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      RDATA_OUT <= `BUS_RST;
      FLAG_IN_OUT <= `BUS_RST;
    end else begin
      FLAG_IN_OUT <= (mode_r == MODE_FLAG) ? swap_bytes(pin_sync) : 16'h0000;
      RDATA_OUT <= (mode_r == MODE_PP8) ? {8'h00, pin_sync[7:0]} : pin_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  AST_FLAG_ENTRY: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (RST_N_IN && SETUP_REG_IN[`FLAG_MODE_BIT] && !PORT_EN_IN) |=> mode_r == MODE_FLAG)
    else $error("flag mode not entered");
  AST_FLAG_MAP: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    mode_r == MODE_FLAG |=> BUS_PIN_OUT == {$past(FLAG_OUT_IN[7:0]), $past(FLAG_OUT_IN[15:8])})
    else $error("flag mapping wrong");
  AST_PP8_ADDR: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (mode_r == MODE_PP8 && LATCH_IN) |=> BUS_PIN_OUT == $past(ADDR_IN[23:8]) && LATCH_OUT)
    else $error("8-bit address phase wrong");
  AST_PP8_DATA: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (mode_r == MODE_PP8 && !LATCH_IN) |=> BUS_PIN_OUT[15:8] == $past(ADDR_IN[7:0]) && BUS_PIN_OE_OUT[15])
    else $error("8-bit data phase wrong");
  AST_PP16_ADDR: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (mode_r == MODE_PP16 && LATCH_IN) |=> BUS_PIN_OUT == $past(ADDR_IN[15:0]) && &BUS_PIN_OE_OUT)
    else $error("16-bit address phase wrong");
  AST_PP16_DATA: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (mode_r == MODE_PP16 && !LATCH_IN && WR_IN) |=> BUS_PIN_OUT == $past(WDATA_IN) && !WR_N_OUT)
    else $error("16-bit data phase wrong");
  AST_STROBE_IDLE: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (mode_r == MODE_FLAG) |=> RD_N_OUT && WR_N_OUT && !LATCH_OUT)
    else $error("strobe active outside port mode");
  AST_FLAG_IN: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    mode_r == MODE_FLAG |=> FLAG_IN_OUT[7:0] == $past(pin_sync[15:8]))
    else $error("flag input mapping wrong");

  ////////////////////////////////////////////////////////////////////////
  // mode selection: the port wins over the flag request
  AST_MODE_PORT: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (RST_N_IN && PORT_EN_IN) |=> mode_r == ($past(WIDE_MODE_IN) ? MODE_PP16 : MODE_PP8))
    else $error("port mode not selected");
  AST_MODE_IDLE: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (RST_N_IN && !PORT_EN_IN && !SETUP_REG_IN[`FLAG_MODE_BIT]) |=> mode_r == MODE_IDLE)
    else $error("idle mode not selected");
  // idle: nothing on the bus, strobes parked
  AST_IDLE_RELEASE: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    mode_r == MODE_IDLE |=> BUS_PIN_OE_OUT == 16'h0000)
    else $error("bus driven in idle mode");
  AST_IDLE_STROBES: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    mode_r == MODE_IDLE |=> RD_N_OUT && WR_N_OUT && !LATCH_OUT)
    else $error("strobe active in idle mode");
  // flag mode: enables and inputs swap like the drive values
  AST_FLAG_OE_MAP: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    mode_r == MODE_FLAG |=> BUS_PIN_OE_OUT == {$past(FLAG_OE_IN[7:0]), $past(FLAG_OE_IN[15:8])})
    else $error("flag enable mapping wrong");
  AST_FLAG_IN_HI: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    mode_r == MODE_FLAG |=> FLAG_IN_OUT[15:8] == $past(pin_sync[7:0]))
    else $error("flag input high byte wrong");
  AST_FLAG_IN_ZERO: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    mode_r != MODE_FLAG |=> FLAG_IN_OUT == 16'h0000)
    else $error("flag inputs live outside flag mode");
  // data phase detail: write drive and read turn-round
  AST_PP8_WR_LOW: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (mode_r == MODE_PP8 && !LATCH_IN && WR_IN) |=> BUS_PIN_OUT[7:0] == $past(WDATA_IN[7:0]) && &BUS_PIN_OE_OUT)
    else $error("8-bit write data wrong");
  AST_PP8_RD_TURN: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (mode_r == MODE_PP8 && !LATCH_IN && !WR_IN) |=> BUS_PIN_OE_OUT == 16'hFF00)
    else $error("8-bit read turn-round wrong");
  AST_PP16_RD_TURN: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (mode_r == MODE_PP16 && !LATCH_IN && !WR_IN) |=> BUS_PIN_OE_OUT == 16'h0000)
    else $error("16-bit read turn-round wrong");
  // port strobes follow their requests one cycle late
  AST_PORT_STROBES: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (mode_r == MODE_PP8 || mode_r == MODE_PP16) |=>
      RD_N_OUT == !$past(RD_IN) && WR_N_OUT == !$past(WR_IN) && LATCH_OUT == $past(LATCH_IN))
    else $error("port strobe wrong");
  // read data path from the synchronised pins
  AST_PP8_RDATA: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    mode_r == MODE_PP8 |=> RDATA_OUT == {8'h00, $past(pin_sync[7:0])})
    else $error("8-bit read data wrong");
  AST_PP16_RDATA: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    mode_r == MODE_PP16 |=> RDATA_OUT == $past(pin_sync))
    else $error("16-bit read data wrong");

endmodule // pin_mux

// >>> rtl/pin_mux_cfg.svh
// constants for the parallel port pin multiplexer
`ifndef PIN_MUX_CFG_SVH
`define PIN_MUX_CFG_SVH
`define FLAG_MODE_BIT 20
`define SETUP_RST 32'h0000_0000
`define LO_BYTE_MSB 7
`define HI_BYTE_LSB 8
`define BUS_RST 16'h0000
`define LATCH_RST 1'b0
`define STRB_N_RST 1'b1
`endif

// >>> rtl/pin_mux_pkg.sv
// types for the parallel port pin multiplexer
package pin_mux_pkg;
  typedef enum logic [1:0] {
    MODE_PP8 = 2'h0,
    MODE_PP16 = 2'h1,
    MODE_FLAG = 2'h3,
    MODE_IDLE = 2'h2
  } pin_mode_t;
endpackage

// >>> rtl/sync2.sv
// two-stage synchroniser for pin inputs
module sync2 #(
  parameter int W = 16
) (
  input wire logic clk_in, // clock
  input wire logic rst_n_in, // async reset
  input wire logic [W-1:0] d_in, // async data
  output logic [W-1:0] q_out // synchronised data
);
  logic [W-1:0] s1_r;
  // first stage feeds only the second
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_r <= '0;
      q_out <= '0;
    end else begin
      s1_r <= d_in;
      q_out <= s1_r;
    end
  end
endmodule // sync2

// >>> sim/ext_latch_mem.sv
// external address latch and memory model on the muxed bus pins
module ext_latch_mem (
  input wire logic clk_in, // core clock
  input wire logic [15:0] pin_out_in, // device pad output
  input wire logic [15:0] pin_oe_in, // device pad enable
  input wire logic latch_in, // latch strobe, active high
  input wire logic rd_n_in, // read strobe, active low
  output logic [15:0] pin_in_out // resolved pin level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] addr_r;
  //////////////////////////////////////////////////////////////
  // hold the address after the strobe falls, data phase needs it
  always_ff @(posedge clk_in) begin
    if (latch_in) begin
      addr_r <= pin_out_in;
    end
  end
  // memory answers reads with inverted address; free pins float up
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      pin_in_out[i] = pin_oe_in[i] ? pin_out_in[i] : (!rd_n_in ? ~addr_r[i] : 1'b1);
    end
  end
endmodule // ext_latch_mem

// >>> sim/tb_top.sv
// self-checking bench for the bus pin multiplexer
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, port_en, wide, latch, rd, wr, latch_o, rd_n, wr_n;
  logic [31:0] setup;
  logic [23:0] addr;
  logic [15:0] wdata, fl_out, fl_oe, pin_in, pin_out, pin_oe, rdata, fl_in;
  int fails = 0;
  int checks_done = 0;
  //////////////////////////////////////////////////////////////
  // design and far-side model
  pin_mux uut (.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .SETUP_REG_IN(setup), .PORT_EN_IN(port_en),
    .WIDE_MODE_IN(wide), .LATCH_IN(latch), .RD_IN(rd), .WR_IN(wr), .ADDR_IN(addr), .WDATA_IN(wdata),
    .FLAG_OUT_IN(fl_out), .FLAG_OE_IN(fl_oe), .BUS_PIN_IN(pin_in), .BUS_PIN_OUT(pin_out),
    .BUS_PIN_OE_OUT(pin_oe), .RDATA_OUT(rdata), .FLAG_IN_OUT(fl_in), .LATCH_OUT(latch_o),
    .RD_N_OUT(rd_n), .WR_N_OUT(wr_n));
  ext_latch_mem mem (.clk_in(clk), .pin_out_in(pin_out), .pin_oe_in(pin_oe), .latch_in(latch_o),
    .rd_n_in(rd_n), .pin_in_out(pin_in));
  // 125 MHz core clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // strobe pins packed as wr_n, rd_n, latch
  task automatic chk_strb(input logic [2:0] exp);
    chk({13'h0000, wr_n, rd_n, latch_o}, {13'h0000, exp});
  endtask
  // waits are generous so mode and sync latency both settle
  task automatic mode(input logic [31:0] s, input logic en, input logic wd);
    @(posedge clk);
    {setup, port_en, wide} <= {s, en, wd};
    repeat (4) @(posedge clk);
  endtask
  task automatic go(input logic l, input logic r, input logic w);
    @(posedge clk);
    {latch, rd, wr} <= {l, r, w};
    repeat (6) @(posedge clk);
    @(negedge clk);
  endtask
  //////////////////////////////////////////////////////////////
  // 8-bit write then read
  task automatic s_port8;
    mode(32'h0000_0000, 1'b1, 1'b0);
    {addr, wdata} <= {24'hA5C33C, 16'h1E96};
    go(1'b1, 1'b0, 1'b0);
    chk(pin_out, 16'hA5C3);
    chk(pin_oe, 16'hFFFF);
    chk_strb(3'h7);
    go(1'b0, 1'b0, 1'b1);
    chk(pin_out, 16'h3C96);
    chk_strb(3'h2);
    go(1'b0, 1'b1, 1'b0);
    chk(pin_oe, 16'hFF00);
    chk(rdata, 16'h003C);
    chk_strb(3'h4);
  endtask
  // 16-bit with flag bit set but port enabled: port keeps pins
  task automatic s_port16;
    mode(32'h0010_0000, 1'b1, 1'b1);
    {addr, wdata} <= {24'h12B4E1, 16'h7F08};
    go(1'b1, 1'b0, 1'b0);
    chk(pin_out, 16'hB4E1);
    go(1'b0, 1'b0, 1'b1);
    chk(pin_out, 16'h7F08);
    go(1'b0, 1'b1, 1'b0);
    chk(pin_oe, 16'h0000);
    chk(rdata, 16'h4B1E);
    chk(fl_in, 16'h0000);
  endtask
  // reset in mid-run with the port enabled, then back to work
  task automatic s_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(pin_oe, 16'h0000);
    chk(pin_out, 16'h0000);
    chk(rdata, 16'h0000);
    chk_strb(3'h6);
    @(posedge clk);
    rst_n <= 1'b1;
    // mode settles one edge after release, strobes one edge later
    @(posedge clk);
    @(negedge clk);
    chk_strb(3'h6);
    @(posedge clk);
    @(negedge clk);
    chk_strb(3'h4);
    go(1'b1, 1'b0, 1'b0);
    chk(pin_out, 16'hB4E1);
    chk_strb(3'h7);
  endtask
  // flag mode byte swap, then idle with strobes held off
  task automatic s_flag;
    mode(32'h0010_0000, 1'b0, 1'b0);
    {fl_out, fl_oe} <= {16'h12EF, 16'h00FF};
    go(1'b1, 1'b1, 1'b1);
    chk(pin_oe, 16'hFF00);
    chk(pin_out & pin_oe, 16'hEF00);
    chk(fl_in, 16'hFFEF);
    chk_strb(3'h6);
    mode(32'h0000_0000, 1'b0, 1'b0);
    go(1'b0, 1'b0, 1'b0);
    chk(pin_oe, 16'h0000);
    chk(fl_in, 16'h0000);
    chk_strb(3'h6);
  endtask
  //////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic end_sim;
    $display("checks=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // reset for 20 cycles, then the scenarios
  initial begin
    {rst_n, port_en, wide, latch, rd, wr, setup, addr} = 62'h0;
    {wdata, fl_out, fl_oe} = 48'h0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    s_port8();
    s_port16();
    s_reset();
    s_flag();
    end_sim();
  end
endmodule // tb_top
